// File: sfr_read_engine.sv
// serial flash command engine: address mode and single/dual/quad reads
// Function
// - after reset, address-bearing instructions use 24-bit addresses
// - enter-wide-address sets configuration bit5 and selects 32-bit addresses
// - wide mode ends only by exit instruction, reset or power-off
// - exit-wide-address clears bit5 and restores 24-bit addressing
// - wide mode changes only address width; id and parameter reads stay 24-bit
// - plain read samples address on rising edges, shifts data on falling
// - address increments after each byte, wraps to zero past the top
// - plain read: address on input line, no dummy, data until deselect
// - fast read: address on one line, 8 dummy clocks default, data falling
// - fast, dual and quad reads are rejected while a write cycle runs
// - dual-output read: one-line address, 8 dummies default, two bits per edge
// - dual-I/O read: two-line address, 4 dummies default, two-bit data
// - quad-output read: one-line address, 8 dummies default, four bits per edge
// - configuration bits 6 and 7 select the dummy clock count
// - in 24-bit mode the extended-address bit reaches the upper array
`timescale 1ns/1ps
module sfr_read_engine
  import sfr_pkg::*;
#(
  parameter int ADDR_W = ARRAY_ADDR_W,
  parameter int DEPTH  = FIFO_DEPTH
) (
  // system
  input  wire logic              clk_sys_in,
  input  wire logic              reset_in,
  // serial pins
  input  wire logic              cs_n_in,
  input  wire logic              sclk_in,
  input  wire logic [3:0]        data_line_in,
  output logic      [3:0]        data_line_out,
  output logic      [3:0]        data_line_oe_out,
  // status and configuration bits
  input  wire logic              busy_in,
  input  wire logic              quad_enable_bit_in,
  input  wire logic              dummy_count_bit_lo_in,
  input  wire logic              dummy_count_bit_hi_in,
  input  wire logic              extended_address_bit_in,
  output logic                   wide_address_flag_out,
  // flash array port
  output logic                   arr_req_out,
  output logic      [ADDR_W-1:0] arr_addr_out,
  input  wire logic [7:0]        arr_data_in,
  input  wire logic              arr_valid_in,
  output logic                   arr_ready_out
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CMD,
    ST_ADDR,
    ST_DUMMY,
    ST_DATA,
    ST_SKIP
  } sfr_phase_t;

  typedef struct packed {
    logic              cs_m;
    logic              cs_s;
    logic              sclk_m;
    logic              sclk_s;
    logic              sclk_p;
    logic [3:0]        din_m;
    logic [3:0]        din_s;
    sfr_phase_t        st;
    logic [7:0]        op;
    logic [5:0]        cnt;
    logic [5:0]        alen;
    logic [3:0]        dlen;
    logic [2:0]        alanes;
    logic [2:0]        olanes;
    logic              nodata;
    logic [31:0]       addr;
    logic              wide;
    logic [ADDR_W-1:0] fa;
    logic              fetching;
    logic              pending;
    logic              req;
    logic [ADDR_W-1:0] raddr;
    logic              rdy;
    logic [7:0]        sh;
    logic [3:0]        bl;
    logic [3:0]        dout;
    logic [3:0]        oe;
  } sfr_state_t;

  sfr_state_t q;
  sfr_state_t d;

  logic       rise;
  logic       fall;
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic       fifo_pop;
  logic [7:0] fifo_data;
  logic [1:0] dc;

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  // dummy count: one shared table; dual-I/O differs only at setting 0 (4 instead of 8)
  function automatic logic [3:0] dummy_cycles(input logic dual_io, input logic [1:0] sel);
    logic [3:0] r;
    r = DUMMY_8;
    case (sel)
      2'h0:    r = dual_io ? DUMMY_4 : DUMMY_8;
      2'h1:    r = DUMMY_6;
      2'h2:    r = DUMMY_8;
      default: r = DUMMY_10;
    endcase
    return r;
  endfunction : dummy_cycles

  // top bits of a byte placed on the lines used for the width
  function automatic logic [3:0] lane_bits(input logic [7:0] b, input logic [2:0] lanes);
    logic [3:0] r;
    r = 4'h0;
    case (lanes)
      LANES_1: r = {2'h0, b[7], 1'b0};
      LANES_2: r = {2'h0, b[7:6]};
      default: r = b[7:4];
    endcase
    return r;
  endfunction : lane_bits

  function automatic logic [3:0] lane_oe(input logic [2:0] lanes);
    logic [3:0] r;
    r = 4'hF;
    case (lanes)
      LANES_1: r = 4'h2;
      LANES_2: r = 4'h3;
      default: r = 4'hF;
    endcase
    return r;
  endfunction : lane_oe

  assign dc   = {dummy_count_bit_hi_in, dummy_count_bit_lo_in};
  assign rise = q.sclk_s && !q.sclk_p;
  assign fall = !q.sclk_s && q.sclk_p;
  // a byte is taken only when the shifter has run dry on a falling edge
  assign fifo_pop = (q.st == ST_DATA) && fall && (q.bl == 4'h0) && fifo_out_valid;

  // ---------------------------------------------------------------------------
  // read-data buffer
  // ---------------------------------------------------------------------------
  sfr_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_sys_in    (clk_sys_in),
    .reset_in      (reset_in),
    .flush_in      (!q.cs_s),
    .in_valid_in   (arr_valid_in && q.fetching),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (arr_data_in),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (fifo_pop),
    .out_data_out  (fifo_data)
  );

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    logic [5:0]  n;
    logic [31:0] a;
    logic [31:0] full;
    logic [7:0]  b;
    n    = '0;
    a    = '0;
    full = '0;
    b    = '0;
    d    = q;

    // pins cross into the system clock through two flops each
    d.cs_m   = !cs_n_in;
    d.cs_s   = q.cs_m;
    d.sclk_m = sclk_in;
    d.sclk_s = q.sclk_m;
    d.sclk_p = q.sclk_s;
    d.din_m  = data_line_in;
    d.din_s  = q.din_m;
    d.req    = 1'b0;

    // array fetch: one request in flight, only while the buffer has room
    if (arr_valid_in) begin
      d.pending = 1'b0;
    end
    if (q.fetching && !q.pending && !q.req && fifo_in_ready) begin
      d.req     = 1'b1;
      d.raddr   = q.fa;
      d.pending = 1'b1;
      d.fa      = q.fa + 1'b1;
    end
    d.rdy = d.pending;

    if (!q.cs_s) begin
      // deselect ends any command at once and releases the lines
      d.st       = ST_IDLE;
      d.oe       = 4'h0;
      d.fetching = 1'b0;
    end else begin
      case (q.st)
        ST_IDLE: begin
          d.st  = ST_CMD;
          d.cnt = '0;
          d.op  = '0;
        end
        ST_CMD: begin
          if (rise) begin
            d.op  = {q.op[6:0], q.din_s[0]};
            d.cnt = q.cnt + 1'b1;
            if (q.cnt == 6'd7) begin
              d.cnt    = '0;
              d.st     = ST_ADDR;
              d.alanes = LANES_1;
              d.olanes = LANES_1;
              d.dlen   = DUMMY_NONE;
              d.nodata = 1'b0;
              d.alen   = q.wide ? ADDR_BITS_WIDE : ADDR_BITS_NARROW;
              case (d.op)
                // lone-byte instructions; extra clocks are simply ignored
                OP_ENTER_WIDE: begin
                  d.wide = 1'b1;
                  d.st   = ST_SKIP;
                end
                OP_EXIT_WIDE: begin
                  d.wide = 1'b0;
                  d.st   = ST_SKIP;
                end
                OP_PLAIN_READ: begin
                  d.dlen = DUMMY_NONE;
                end
                OP_FAST_READ: begin
                  d.dlen = dummy_cycles(1'b0, dc);
                  if (busy_in) d.st = ST_SKIP;
                end
                OP_DUAL_OUT_READ: begin
                  d.dlen   = dummy_cycles(1'b0, dc);
                  d.olanes = LANES_2;
                  if (busy_in) d.st = ST_SKIP;
                end
                OP_DUAL_IO_READ: begin
                  d.dlen   = dummy_cycles(1'b1, dc);
                  d.alanes = LANES_2;
                  d.olanes = LANES_2;
                  if (busy_in) d.st = ST_SKIP;
                end
                OP_QUAD_OUT_READ: begin
                  d.dlen   = dummy_cycles(1'b0, dc);
                  d.olanes = LANES_4;
                  // without quad enable the upper lines are not ours to drive
                  if (busy_in || !quad_enable_bit_in) d.st = ST_SKIP;
                end
                OP_PARAM_TBL_READ, OP_SIGNATURE_READ, OP_MAKER_ID_READ: begin
                  // served elsewhere; only the address is absorbed here
                  d.alen   = ADDR_BITS_NARROW;
                  d.nodata = 1'b1;
                end
                default: begin
                  d.st = ST_SKIP;
                end
              endcase
            end
          end
        end
        ST_ADDR: begin
          if (rise) begin
            if (q.alanes == LANES_2) begin
              a = {q.addr[29:0], q.din_s[1:0]};
            end else begin
              a = {q.addr[30:0], q.din_s[0]};
            end
            d.addr = a;
            n      = q.cnt + 6'(q.alanes);
            d.cnt  = n;
            if (n >= q.alen) begin
              d.cnt = '0;
              full  = q.wide ? a : {7'h0, extended_address_bit_in, a[23:0]};
              d.fa  = full[ADDR_W-1:0];
              if (q.nodata) begin
                d.st = ST_SKIP;
              end else begin
                d.fetching = 1'b1;
                d.bl       = 4'h0;
                d.st       = (q.dlen == DUMMY_NONE) ? ST_DATA : ST_DUMMY;
              end
            end
          end
        end
        ST_DUMMY: begin
          if (rise) begin
            d.cnt = q.cnt + 1'b1;
            if (q.cnt == 6'(q.dlen - 1'b1)) begin
              d.st = ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (fall) begin
            d.oe = lane_oe(q.olanes);
            // an empty buffer here shifts out zero bits; array must keep up
            b      = (q.bl == 4'h0 && fifo_out_valid) ? fifo_data : q.sh;
            d.dout = lane_bits(b, q.olanes);
            d.sh   = b << q.olanes;
            d.bl   = (q.bl == 4'h0) ? BYTE_BITS - 4'(q.olanes) : q.bl - 4'(q.olanes);
          end
        end
        ST_SKIP: begin
          d.oe = 4'h0;
        end
        default: begin
          d.st = ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign data_line_out         = q.dout;
  assign data_line_oe_out      = q.oe;
  assign wide_address_flag_out = q.wide;
  assign arr_req_out           = q.req;
  assign arr_addr_out          = q.raddr;
  assign arr_ready_out         = q.rdy;

endmodule : sfr_read_engine

// File: sfr_pkg.sv
// constants for the serial flash read and address-mode command engine
package sfr_pkg;

  // ---------------------------------------------------------------------------
  // instruction codes (plain defaults, override per device)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OP_PLAIN_READ     = 8'h03;
  localparam logic [7:0] OP_FAST_READ      = 8'h0B;
  localparam logic [7:0] OP_DUAL_OUT_READ  = 8'h3B;
  localparam logic [7:0] OP_DUAL_IO_READ   = 8'hBB;
  localparam logic [7:0] OP_QUAD_OUT_READ  = 8'h6B;
  localparam logic [7:0] OP_ENTER_WIDE     = 8'hB7;
  localparam logic [7:0] OP_EXIT_WIDE      = 8'hE9;
  localparam logic [7:0] OP_PARAM_TBL_READ = 8'h5A;
  localparam logic [7:0] OP_SIGNATURE_READ = 8'hAB;
  localparam logic [7:0] OP_MAKER_ID_READ  = 8'h90;

  // ---------------------------------------------------------------------------
  // configuration register field positions
  // ---------------------------------------------------------------------------
  localparam int CFG_WIDE_ADDR_POS = 5;
  localparam int CFG_DUMMY_LO_POS  = 6;
  localparam int CFG_DUMMY_HI_POS  = 7;

  // ---------------------------------------------------------------------------
  // phase lengths
  // ---------------------------------------------------------------------------
  localparam logic [5:0] ADDR_BITS_NARROW = 6'h18;
  localparam logic [5:0] ADDR_BITS_WIDE   = 6'h20;
  localparam logic [3:0] DUMMY_NONE       = 4'h0;
  localparam logic [3:0] DUMMY_4          = 4'h4;
  localparam logic [3:0] DUMMY_6          = 4'h6;
  localparam logic [3:0] DUMMY_8          = 4'h8;
  localparam logic [3:0] DUMMY_10         = 4'hA;
  localparam logic [3:0] BYTE_BITS        = 4'h8;
  localparam logic [2:0] LANES_1          = 3'h1;
  localparam logic [2:0] LANES_2          = 3'h2;
  localparam logic [2:0] LANES_4          = 3'h4;

  // ---------------------------------------------------------------------------
  // array and buffer shape
  // ---------------------------------------------------------------------------
  localparam int ARRAY_ADDR_W = 26;
  localparam int FIFO_WIDTH   = 8;
  localparam int FIFO_DEPTH   = 32;

endpackage : sfr_pkg

// File: sfr_fifo.sv
// read-data fifo between the flash array and the serial shifter
`timescale 1ns/1ps
module sfr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             reset_in,
  input  wire logic             flush_in,
  // fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr;
    logic [PW-1:0]               rd;
    logic [PW:0]                 cnt;
  } sfr_fifo_state_t;

  sfr_fifo_state_t q;
  sfr_fifo_state_t d;
  logic            push;
  logic            pop;

  assign in_ready_out  = (q.cnt != (PW+1)'(DEPTH));
  assign out_valid_out = (q.cnt != '0);
  assign out_data_out  = q.mem[q.rd];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  // ---------------------------------------------------------------------------
  // pointers and storage
  // ---------------------------------------------------------------------------
  always_comb begin
    d = q;
    if (flush_in) begin
      d.wr  = '0;
      d.rd  = '0;
      d.cnt = '0;
    end else begin
      if (push) begin
        d.mem[q.wr] = in_data_in;
        d.wr        = (q.wr == PW'(DEPTH - 1)) ? '0 : q.wr + 1'b1;
      end
      if (pop) begin
        d.rd = (q.rd == PW'(DEPTH - 1)) ? '0 : q.rd + 1'b1;
      end
      d.cnt = q.cnt + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule : sfr_fifo

// File: sfr_read_engine_props.sv
// concurrent checks on the read engine ports
`timescale 1ns/1ps
module sfr_read_engine_props
  import sfr_pkg::*;
#(
  parameter int ADDR_W = ARRAY_ADDR_W,
  parameter int DEPTH  = FIFO_DEPTH
) (
  // watched ports
  input  wire logic              clk_sys_in,
  input  wire logic              reset_in,
  input  wire logic              cs_n_in,
  input  wire logic [3:0]        data_line_oe_out,
  input  wire logic              wide_address_flag_out,
  input  wire logic              arr_req_out,
  input  wire logic [ADDR_W-1:0] arr_addr_out,
  input  wire logic              arr_valid_in,
  input  wire logic              arr_ready_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  logic              seen_q;
  logic [ADDR_W-1:0] prev_q;
  // clear wins over set so two selections are never linked
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      seen_q <= 1'b0;
      prev_q <= '0;
    end else begin
      if (arr_req_out) prev_q <= arr_addr_out;
      seen_q <= cs_n_in ? 1'b0 : (seen_q | arr_req_out);
    end
  end
  sequence cs_idle_s;
    cs_n_in[*6];
  endsequence
  sequence answer_s;
    arr_valid_in && arr_ready_out;
  endsequence
  reset_narrow_a: assert property ($fell(reset_in) |-> !wide_address_flag_out)
    else $error("wide flag set after reset");
  mode_in_cmd_a: assert property ($changed(wide_address_flag_out) |-> !cs_n_in)
    else $error("address mode changed while deselected");
  lanes_legal_a: assert property (data_line_oe_out inside {4'h0, 4'h2, 4'h3, 4'hF})
    else $error("illegal lane enable pattern");
  idle_undriven_a: assert property (cs_idle_s |-> data_line_oe_out == 4'h0)
    else $error("lines driven while deselected");
  req_pulse_a: assert property (arr_req_out |=> !arr_req_out && arr_ready_out)
    else $error("array request not a single pulse");
  req_gap_a: assert property (answer_s |=> !arr_req_out && !arr_ready_out)
    else $error("array request too soon after answer");
  addr_step_a: assert property (arr_req_out && seen_q |-> arr_addr_out == prev_q + 1'b1)
    else $error("array address did not step by one");
  no_req_idle_a: assert property (cs_idle_s |-> !arr_req_out)
    else $error("array request while deselected");
endmodule : sfr_read_engine_props

// File: sfr_host_model.sv
// host-side serial controller model driving the flash pins
`timescale 1ns/1ps
module sfr_host_model (
  // system
  input  wire logic       clk_sys_in,
  // serial pins
  output logic            cs_n_out,
  output logic            sclk_out,
  output logic [3:0]      wire_out,
  input  wire logic [3:0] dev_data_in,
  input  wire logic [3:0] dev_oe_in
);
  logic [3:0] hv, hen;
  logic       tog;
  logic [7:0] sh;
  int         nbit, ob, oa;
  logic [7:0] q[$];
  // released lines toggle so a stale level never passes for data
  assign wire_out = (dev_oe_in & dev_data_in) | (~dev_oe_in & ((hen & hv) | (~hen & {4{tog}})));
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    hv = 4'h0;
    hen = 4'h0;
    tog = 1'b0;
  end
  task automatic hp;
    repeat (10) @(negedge clk_sys_in);
  endtask : hp
  // one serial clock; lanes are sampled just before the rise
  task automatic tick(input logic [3:0] v, input logic [3:0] en, input int dl);
    hv = v;
    hen = en;
    tog = ~tog;
    hp();
    if (dl == 0) begin
      if (dev_oe_in != 4'h0) ob++;
    end else begin
      if (dev_oe_in != 4'h0) oa++;
      sh = (dl == 4) ? {sh[3:0], wire_out} :
           (dl == 2) ? {sh[5:0], wire_out[1:0]} : {sh[6:0], wire_out[1]};
      nbit += dl;
      if (nbit == 8) begin
        q.push_back(sh);
        nbit = 0;
      end
    end
    sclk_out = 1'b1;
    hp();
    sclk_out = 1'b0;
  endtask : tick
  task automatic xfer(input logic [7:0] op, input logic [31:0] ad, input int nab,
                      input int al, input int nd, input int dl, input int nb);
    logic [3:0] m;
    m = (al == 2) ? 4'h3 : 4'h1;
    ob = 0;
    oa = 0;
    nbit = 0;
    q = {};
    cs_n_out = 1'b0;
    hp();
    for (int i = 7; i >= 0; i--) tick({3'h0, op[i]}, 4'h1, 0);
    for (int i = nab / al - 1; i >= 0; i--) tick(4'(ad >> (i * al)) & m, m, 0);
    for (int i = 0; i < nd; i++) tick(4'h0, 4'h0, 0);
    for (int i = 0; i < nb * 8 / dl; i++) tick(4'h0, 4'h0, dl);
    cs_n_out = 1'b1;
    hen = 4'h0;
    hp();
    hp();
  endtask : xfer
endmodule : sfr_host_model

// File: tb_sfr_read_engine.sv
// testbench for the serial flash read engine
`timescale 1ns/1ps
module tb_sfr_read_engine;
  import sfr_pkg::*;
  logic        clk_sys_in, reset_in, cs_n, sclk, busy, qe, dlo, dhi, ext;
  logic        flag, req, rdy, avalid;
  logic [3:0]  wire_l, dout, doe;
  logic [7:0]  adata;
  logic [25:0] aaddr, pa;
  int          errors, compares, cycles, lat, cnt;
  int          dfast[4] = '{8, 6, 8, 10};
  logic [7:0]  rej_op[4] = '{OP_FAST_READ, OP_DUAL_OUT_READ, OP_DUAL_IO_READ, OP_QUAD_OUT_READ};

  sfr_read_engine sfr_read_engine_i (
    .clk_sys_in              (clk_sys_in),
    .reset_in                (reset_in),
    .cs_n_in                 (cs_n),
    .sclk_in                 (sclk),
    .data_line_in            (wire_l),
    .data_line_out           (dout),
    .data_line_oe_out        (doe),
    .busy_in                 (busy),
    .quad_enable_bit_in      (qe),
    .dummy_count_bit_lo_in   (dlo),
    .dummy_count_bit_hi_in   (dhi),
    .extended_address_bit_in (ext),
    .wide_address_flag_out   (flag),
    .arr_req_out             (req),
    .arr_addr_out            (aaddr),
    .arr_data_in             (adata),
    .arr_valid_in            (avalid),
    .arr_ready_out           (rdy)
  );
  sfr_host_model sfr_host_model_i (
    .clk_sys_in  (clk_sys_in),
    .cs_n_out    (cs_n),
    .sclk_out    (sclk),
    .wire_out    (wire_l),
    .dev_data_in (dout),
    .dev_oe_in   (doe)
  );

  function automatic logic [7:0] dat(input logic [25:0] a);
    return a[7:0] ^ a[23:16] ^ {6'h00, a[25:24]};
  endfunction : dat
  // array answers after lat cycles; idle data inverts so stale bytes never match
  always @(negedge clk_sys_in) begin
    avalid <= !req && cnt == 1;
    adata  <= (!req && cnt == 1) ? dat(pa) : ~adata;
    cnt    <= req ? lat : (cnt > 0 ? cnt - 1 : 0);
    if (req) pa <= aaddr;
  end
  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk
  task automatic wrap_up;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  task automatic rd(input logic [7:0] op, input logic [31:0] ad, input int nab, input int al,
                    input int nd, input int dl, input logic [25:0] base);
    sfr_host_model_i.xfer(op, ad, nab, al, nd, dl, 2);
    chk("early drive", sfr_host_model_i.ob, 0);
    chk("byte count", sfr_host_model_i.q.size(), 2);
    for (int i = 0; i < 2; i++) chk("read byte", sfr_host_model_i.q[i], dat(base + 26'(i)));
  endtask : rd
  // a run reaching 60000 cycles would mean a lost handshake
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      wrap_up();
    end
  end
  initial begin
    reset_in = 1'b1;
    {busy, qe, dlo, dhi, ext} = 5'h00;
    adata = 8'h00;
    lat = 1;
    repeat (10) @(negedge clk_sys_in);
    reset_in = 1'b0;
    repeat (6) @(negedge clk_sys_in);
    chk("wide flag", flag, 0);
    rd(OP_PLAIN_READ, 32'h00123456, 24, 1, 0, 1, 26'h0123456);
    ext = 1'b1;
    rd(OP_PLAIN_READ, 32'h00FFFFFF, 24, 1, 0, 1, 26'h1FFFFFF);
    ext = 1'b0;
    lat = 5;
    for (int k = 0; k < 4; k++) begin
      {dhi, dlo} = 2'(k);
      rd(OP_FAST_READ, 32'h00000010, 24, 1, dfast[k], 1, 26'h0000010);
    end
    lat = 1;
    {dhi, dlo} = 2'h1;
    rd(OP_DUAL_OUT_READ, 32'h00000A5C, 24, 1, 6, 2, 26'h0000A5C);
    {dhi, dlo} = 2'h0;
    rd(OP_DUAL_IO_READ, 32'h00ABCDEF, 24, 2, 4, 2, 26'h0ABCDEF);
    qe = 1'b1;
    rd(OP_QUAD_OUT_READ, 32'h00345678, 24, 1, 8, 4, 26'h0345678);
    busy = 1'b1;
    foreach (rej_op[k]) begin
      sfr_host_model_i.xfer(rej_op[k], 32'h0, 24, 1, 8, 1, 1);
      chk("refused drive", sfr_host_model_i.oa, 0);
    end
    busy = 1'b0;
    qe = 1'b0;
    sfr_host_model_i.xfer(OP_QUAD_OUT_READ, 32'h0, 24, 1, 8, 1, 1);
    chk("quad refused drive", sfr_host_model_i.oa, 0);
    sfr_host_model_i.xfer(8'h00, 32'h0, 24, 1, 8, 1, 1);
    chk("unknown op drive", sfr_host_model_i.oa, 0);
    qe = 1'b1;
    sfr_host_model_i.xfer(OP_ENTER_WIDE, 32'h0, 0, 1, 0, 1, 0);
    chk("wide flag", flag, 1);
    rd(OP_PLAIN_READ, 32'h03FFFFFF, 32, 1, 0, 1, 26'h3FFFFFF);
    sfr_host_model_i.xfer(OP_MAKER_ID_READ, 32'h0, 24, 1, 0, 1, 1);
    chk("id read drive", sfr_host_model_i.oa, 0);
    sfr_host_model_i.xfer(OP_PARAM_TBL_READ, 32'h0, 24, 1, 0, 1, 1);
    chk("table read drive", sfr_host_model_i.oa, 0);
    sfr_host_model_i.xfer(OP_SIGNATURE_READ, 32'h0, 24, 1, 0, 1, 1);
    chk("signature drive", sfr_host_model_i.oa, 0);
    chk("wide flag", flag, 1);
    rd(OP_FAST_READ, 32'h02000001, 32, 1, 8, 1, 26'h2000001);
    sfr_host_model_i.xfer(OP_EXIT_WIDE, 32'h0, 0, 1, 0, 1, 0);
    chk("wide flag", flag, 0);
    rd(OP_PLAIN_READ, 32'h00000100, 24, 1, 0, 1, 26'h0000100);
    sfr_host_model_i.xfer(OP_ENTER_WIDE, 32'h0, 0, 1, 0, 1, 0);
    reset_in = 1'b1;
    repeat (2) @(negedge clk_sys_in);
    reset_in = 1'b0;
    repeat (6) @(negedge clk_sys_in);
    chk("wide flag", flag, 0);
    // a stuck wide flag would swallow eight more address bits here
    rd(OP_PLAIN_READ, 32'h00000200, 24, 1, 0, 1, 26'h0000200);
    wrap_up();
  end
endmodule : tb_sfr_read_engine

bind sfr_read_engine sfr_read_engine_props #(
  .ADDR_W (ADDR_W),
  .DEPTH  (DEPTH)
) sfr_read_engine_props_i (
  .clk_sys_in            (clk_sys_in),
  .reset_in              (reset_in),
  .cs_n_in               (cs_n_in),
  .data_line_oe_out      (data_line_oe_out),
  .wide_address_flag_out (wide_address_flag_out),
  .arr_req_out           (arr_req_out),
  .arr_addr_out          (arr_addr_out),
  .arr_valid_in          (arr_valid_in),
  .arr_ready_out         (arr_ready_out)
);
